/* inc/relay_pkg.sv */
// Package for the repeater forwarding block: modes, field positions, reset values and timing counts.
// Assumes a single 25 MHz system clock shared by every file that imports it.
package relay_pkg;

    // ------------------------------------------------------------
    // Operating modes and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_WAKE,
        MODE_CONFIG,
        MODE_SLEEP
    } op_mode_type;

    localparam int CLK_FREQ_HZ = 25_000_000;
    // Time the parameter reload takes, in microseconds.
    localparam int RELOAD_TIME_US = 20;
    localparam int RELOAD_CYCLES = (RELOAD_TIME_US * (CLK_FREQ_HZ / 1_000_000) < 1) ? 1 :
        RELOAD_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int RELOAD_CNT_W = 10;

    // ------------------------------------------------------------
    // Field positions and limits
    // ------------------------------------------------------------
    localparam int REPEAT_EN_BIT = 5;
    localparam int ADDR_HIGH_LSB = 8;
    localparam logic [6:0] CHANNEL_MAX = 7'h40;
    localparam logic [7:0] NETWORK_IDENT_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] OPTION3_RESET = 8'h03;
    localparam logic [6:0] CHANNEL_RESET = 7'h28;

endpackage

/* hdl/reload_timer.sv */
// Reload timer: holds a busy level for a fixed count after a start pulse.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module reload_timer (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Control
    input wire logic i_start,
    output logic o_busy
);
    import relay_pkg::*;

    logic [RELOAD_CNT_W-1:0] count;

    // ------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------
    // Reset itself counts as a reload, so the timer starts loaded.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_start) begin
            count <= RELOAD_CNT_W'(RELOAD_CYCLES);
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign o_busy = (count != '0);
endmodule

/* hdl/relay_forwarder.sv */
// Repeater forwarding logic: relays packets between the two networks named by the address bytes.
// Assumes the radio side presents received packet headers as one-cycle strobes on i_clk_sys.
`timescale 1ns/1ps

module relay_forwarder (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Mode pins from the host
    input wire logic i_mode_select_0,
    input wire logic i_mode_select_1,
    // Configuration written by the host in configuration mode
    input wire logic i_cfg_write,
    input wire logic [7:0] i_addr_high_byte,
    input wire logic [7:0] i_addr_low_byte,
    input wire logic [7:0] i_network_ident,
    input wire logic [6:0] i_channel,
    input wire logic [7:0] i_option3,
    // Received packet header from the radio
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_network_ident,
    input wire logic [15:0] i_rx_src_addr,
    input wire logic [15:0] i_rx_dst_addr,
    // Host transmit request
    input wire logic i_host_tx_req,
    // Outputs
    output logic o_busy_n,
    output logic o_relay_tx,
    output logic [7:0] o_relay_network_ident,
    output logic o_host_deliver,
    output logic o_radio_tx,
    output logic o_low_power,
    output logic o_repeating,
    output logic o_cfg_reject
);
    import relay_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] mode_meta;
    logic [1:0] mode_sync;
    op_mode_type mode;
    op_mode_type prev_mode;
    logic [7:0] addr_high_byte;
    logic [7:0] addr_low_byte;
    logic [7:0] network_ident;
    logic [6:0] channel;
    logic [7:0] option3;
    logic repeating;
    logic reload_start;
    logic reload_busy;
    logic in_pair;
    logic [7:0] other_net;
    logic reloading;

    // Maps the two pin levels onto a mode.
    function automatic op_mode_type decode_mode(input logic [1:0] pins);
        case (pins)
            2'b00: decode_mode = MODE_NORMAL;
            2'b01: decode_mode = MODE_WAKE;
            2'b10: decode_mode = MODE_CONFIG;
            default: decode_mode = MODE_SLEEP;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Mode pins
    // ------------------------------------------------------------
    // Pins are asynchronous to the clock, so two stages come first.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mode_meta <= 2'b00;
            mode_sync <= 2'b00;
        end else begin
            mode_meta <= {i_mode_select_1, i_mode_select_0};
            mode_sync <= mode_meta;
        end
    end

    assign mode = decode_mode(mode_sync);

    // Previous mode, used to spot the exit from sleep.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            prev_mode <= MODE_NORMAL;
        end else begin
            prev_mode <= mode;
        end
    end

    // ------------------------------------------------------------
    // Parameter reload
    // ------------------------------------------------------------
    assign reload_start = (prev_mode == MODE_SLEEP) && (mode != MODE_SLEEP);

    reload_timer u_reload (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(reload_start),
        .o_busy(reload_busy)
    );

    // The start cycle counts as reloading too, because the timer only loads on that edge.
    assign reloading = reload_busy || reload_start;

    // The ready line stays low through reset and every reload.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_busy_n <= 1'b0;
        end else begin
            o_busy_n <= !reloading;
        end
    end

    // ------------------------------------------------------------
    // Configuration store
    // ------------------------------------------------------------
    // Writes count only in configuration mode and outside a reload; an out of range
    // channel rejects the whole write so the stored set stays consistent.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            addr_high_byte <= ADDR_RESET[ADDR_HIGH_LSB +: 8];
            addr_low_byte <= ADDR_RESET[7:0];
            network_ident <= NETWORK_IDENT_RESET;
            channel <= CHANNEL_RESET;
            option3 <= OPTION3_RESET;
            o_cfg_reject <= 1'b0;
        end else begin
            o_cfg_reject <= 1'b0;
            if (i_cfg_write && mode == MODE_CONFIG && !reloading) begin
                if (i_channel > CHANNEL_MAX) begin
                    o_cfg_reject <= 1'b1;
                end else begin
                    addr_high_byte <= i_addr_high_byte;
                    addr_low_byte <= i_addr_low_byte;
                    network_ident <= i_network_ident;
                    channel <= i_channel;
                    option3 <= i_option3;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Repeater state
    // ------------------------------------------------------------
    // Enabling in configuration is not enough: relaying begins only in normal mode.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            repeating <= 1'b0;
        end else begin
            repeating <= option3[REPEAT_EN_BIT] && mode == MODE_NORMAL && !reloading;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_repeating <= 1'b0;
        end else begin
            o_repeating <= repeating;
        end
    end

    // ------------------------------------------------------------
    // Forwarding decision
    // ------------------------------------------------------------
    // The pair replaces the node address and own network identifier entirely.
    assign in_pair = (i_rx_network_ident == addr_high_byte) || (i_rx_network_ident == addr_low_byte);
    assign other_net = (i_rx_network_ident == addr_high_byte) ? addr_low_byte : addr_high_byte;

    // One strobe in gives at most one relay out, so a packet is never sent twice.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_relay_tx <= 1'b0;
            o_relay_network_ident <= 8'h00;
        end else begin
            // No target is this device while relaying: the address bytes are not a node address.
            o_relay_tx <= repeating && i_rx_valid && in_pair;
            if (repeating && i_rx_valid && in_pair) begin
                o_relay_network_ident <= other_net;
            end
        end
    end

    // ------------------------------------------------------------
    // Host side paths
    // ------------------------------------------------------------
    // As a plain node, delivery needs a matching network and source address.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_host_deliver <= 1'b0;
            o_radio_tx <= 1'b0;
            o_low_power <= 1'b0;
        end else begin
            o_host_deliver <= !repeating && mode == MODE_NORMAL && i_rx_valid && i_rx_network_ident == network_ident
                && i_rx_src_addr == {addr_high_byte, addr_low_byte};
            o_radio_tx <= !repeating && i_host_tx_req && mode != MODE_CONFIG && !reloading;
            o_low_power <= !repeating && (mode == MODE_SLEEP || mode == MODE_WAKE);
        end
    end
endmodule

/* test/radio_node_model.sv */
// Model of a far radio node that hands packet headers to the block.
// Assumes its caller is just past a rising clock edge.
`timescale 1ns/1ps
module radio_node_model (
    // Clock
    input wire logic i_clk,
    // Packet header towards the block
    output logic o_valid,
    output logic [7:0] o_network_ident,
    output logic [15:0] o_src,
    output logic [15:0] o_dst
);
    // Idle lines start at zero and carry inverted data after a send, so a stale header cannot pass for a fresh one.
    initial begin
        o_valid = 1'b0;
        o_network_ident = 8'h00;
        o_src = 16'h0000;
        o_dst = 16'h0000;
    end

    // One header strobe for one cycle; fields stay within their widths.
    task automatic send(input logic [7:0] n, input logic [15:0] s, input logic [15:0] d);
        o_valid = 1'b1;
        o_network_ident = n;
        o_src = s;
        o_dst = d;
        @(posedge i_clk);
        #1;
        o_valid = 1'b0;
        o_network_ident = ~n;
        o_src = ~s;
        o_dst = ~d;
    endtask
endmodule

/* test/relay_forwarder_asserts.sv */
// Checker for the repeater forwarding block, bound to its top module.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
module relay_forwarder_asserts
    import relay_pkg::*;
(
    // Clock, reset and inputs
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_mode_select_0,
    input wire logic i_mode_select_1,
    input wire logic i_cfg_write,
    input wire logic [6:0] i_channel,
    input wire logic i_rx_valid,
    // Outputs
    input wire logic o_busy_n,
    input wire logic o_relay_tx,
    input wire logic o_host_deliver,
    input wire logic o_radio_tx,
    input wire logic o_low_power,
    input wire logic o_repeating,
    input wire logic o_cfg_reject
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // --------------------------------------------------
    // Properties
    // --------------------------------------------------
    property p_busy_rst; $fell(i_rst) |-> !o_busy_n [*8]; endproperty
    a_busy_rst: assert property (p_busy_rst) else $error("busy released early after reset");
    property p_relay_ready; o_relay_tx |-> o_busy_n; endproperty
    a_relay_ready: assert property (p_relay_ready) else $error("relay while reloading");
    property p_relay_cause; o_relay_tx |-> $past(i_rx_valid); endproperty
    a_relay_cause: assert property (p_relay_cause) else $error("relay without a header");
    property p_deliver_cause; o_host_deliver |-> $past(i_rx_valid); endproperty
    a_deliver_cause: assert property (p_deliver_cause) else $error("delivery without a header");
    property p_rep_quiet; o_repeating && $past(o_repeating) |-> !o_radio_tx && !o_low_power; endproperty
    a_rep_quiet: assert property (p_rep_quiet) else $error("send or low power while relaying");
    property p_rep_nodel; o_repeating && $past(o_repeating) |-> !o_host_deliver; endproperty
    a_rep_nodel: assert property (p_rep_nodel) else $error("delivery while relaying");
    property p_rep_mode; $rose(o_repeating) |-> !$past(i_mode_select_0, 4) && !$past(i_mode_select_1, 4); endproperty
    a_rep_mode: assert property (p_rep_mode) else $error("relaying outside normal mode");
    property p_reject; o_cfg_reject |-> ($past(i_cfg_write) && $past(i_channel) > CHANNEL_MAX) ||
        ($past(i_cfg_write, 2) && $past(i_channel, 2) > CHANNEL_MAX); endproperty
    a_reject: assert property (p_reject) else $error("reject without a bad channel");
endmodule

bind relay_forwarder relay_forwarder_asserts relay_forwarder_asserts_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_mode_select_0(i_mode_select_0), .i_mode_select_1(i_mode_select_1), .i_cfg_write(i_cfg_write),
    .i_channel(i_channel), .i_rx_valid(i_rx_valid), .o_busy_n(o_busy_n), .o_relay_tx(o_relay_tx),
    .o_host_deliver(o_host_deliver), .o_radio_tx(o_radio_tx), .o_low_power(o_low_power),
    .o_repeating(o_repeating), .o_cfg_reject(o_cfg_reject));

/* test/relay_forwarder_bench.sv */
// Self-checking bench for the repeater forwarding block.
// Assumes a 25 MHz clock and the radio node model as packet source.
`timescale 1ns/1ps
module relay_forwarder_bench;
    import relay_pkg::*;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
    logic clk = 1'b0, rst = 1'b1, m0 = 1'b0, m1 = 1'b0, wr = 1'b0, tx_req = 1'b0;
    logic [7:0] hi = 8'h00, lo = 8'h00, nid = 8'h00, opt = 8'h00;
    logic [6:0] ch = 7'h00;
    logic rv, busy_n, rtx, dl, radio_tx, low_pw, rep, rej;
    logic [7:0] rn, rnet;
    logic [15:0] rs, rd;
    int mismatches = 0, cmp_count = 0, tx_cnt = 0, dl_cnt = 0, rj_cnt = 0;

    // Clock and pulse counters; counting pulses also catches a doubled relay.
    always #20 clk = ~clk;
    always @(posedge clk) begin
        tx_cnt <= tx_cnt + int'(rtx !== 1'b0);
        dl_cnt <= dl_cnt + int'(dl !== 1'b0);
        rj_cnt <= rj_cnt + int'(rej !== 1'b0);
    end

    relay_forwarder relay_forwarder_inst (.i_clk_sys(clk), .i_rst(rst), .i_mode_select_0(m0), .i_mode_select_1(m1),
        .i_cfg_write(wr), .i_addr_high_byte(hi), .i_addr_low_byte(lo), .i_network_ident(nid), .i_channel(ch),
        .i_option3(opt), .i_rx_valid(rv), .i_rx_network_ident(rn), .i_rx_src_addr(rs), .i_rx_dst_addr(rd),
        .i_host_tx_req(tx_req), .o_busy_n(busy_n), .o_relay_tx(rtx), .o_relay_network_ident(rnet), .o_host_deliver(dl),
        .o_radio_tx(radio_tx), .o_low_power(low_pw), .o_repeating(rep), .o_cfg_reject(rej));
    radio_node_model radio_node_model_inst (.i_clk(clk), .o_valid(rv), .o_network_ident(rn), .o_src(rs), .o_dst(rd));

    // --------------------------------------------------
    // Access tasks
    // --------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_mode(input logic s1, input logic s0);
        m1 = s1;
        m0 = s0;
        cyc(8);
    endtask
    task automatic wait_ready;
        int k;
        for (k = 0; k < 700 && busy_n !== 1'b1; k++) cyc(1);
        `CHK(k > 400, 1'b1)
    endtask
    task automatic cfg(input logic [7:0] h, l, n, input logic [6:0] c, input logic [7:0] o, input int erj);
        int rj0;
        rj0 = rj_cnt;
        {hi, lo, nid, ch, opt} = {h, l, n, c, o};
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(3);
        `CHK(rj_cnt - rj0, erj)
    endtask
    task automatic rx(input logic [7:0] n, input logic [15:0] s, d, input int etx, edl, input logic [7:0] enet);
        int tx0;
        int dl0;
        tx0 = tx_cnt;
        dl0 = dl_cnt;
        radio_node_model_inst.send(n, s, d);
        cyc(4);
        `CHK(tx_cnt - tx0, etx)
        `CHK(dl_cnt - dl0, edl)
        if (etx == 1) `CHK(rnet, enet)
    endtask
    task automatic end_of_test;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------
    // Tests
    // --------------------------------------------------
    initial begin
        cyc(16);
        rst = 1'b0;
        cyc(2);
        `CHK(busy_n, 1'b0)
        wait_ready();
        set_mode(1'b1, 1'b0);
        cfg(8'h08, 8'h33, 8'h11, 7'h40, 8'h23, 0);
        cfg(8'h55, 8'h66, 8'h11, 7'h41, 8'h23, 1);
        rx(8'h08, 16'h0001, 16'h1234, 0, 0, 8'h00);
        set_mode(1'b0, 1'b0);
        `CHK(rep, 1'b1)
        rx(8'h08, 16'h0001, 16'h1234, 1, 0, 8'h33);
        rx(8'h33, 16'h0002, 16'h4321, 1, 0, 8'h08);
        rx(8'h11, 16'h0833, 16'h0001, 0, 0, 8'h00);
        rx(8'h08, 16'h0001, 16'h0833, 1, 0, 8'h33);
        rx(8'h12, 16'h0001, 16'h1234, 0, 0, 8'h00);
        tx_req = 1'b1;
        cyc(4);
        `CHK({radio_tx, low_pw}, 2'b00)
        tx_req = 1'b0;
        set_mode(1'b1, 1'b1);
        set_mode(1'b0, 1'b0);
        `CHK(busy_n, 1'b0)
        rx(8'h08, 16'h0001, 16'h1234, 0, 0, 8'h00);
        wait_ready();
        set_mode(1'b1, 1'b0);
        cfg(8'h08, 8'h33, 8'h11, 7'h28, 8'h03, 0);
        set_mode(1'b0, 1'b0);
        `CHK(rep, 1'b0)
        rx(8'h11, 16'h0833, 16'h0001, 0, 1, 8'h00);
        rx(8'h11, 16'h0834, 16'h0001, 0, 0, 8'h00);
        tx_req = 1'b1;
        cyc(2);
        `CHK({radio_tx, low_pw}, 2'b10)
        tx_req = 1'b0;
        rx(8'h08, 16'h0001, 16'h1234, 0, 0, 8'h00);
        end_of_test();
    end

    // Watchdog: the tests need about 1100 cycles.
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule
